/* File: logic/fpsn_norm.sv */
// single-format classifier, normalizer and gradual-underflow packer
`timescale 1ns/1ns

// How it works
// RULE1 - sign bit 0 means positive, 1 means negative
// RULE2 - significand is integer bit plus fraction; integer bit implied when packed
// RULE3 - exponent is the power of two scaling the significand
// RULE4 - word is 32 bits; stored exponent is true exponent plus 127
// RULE5 - stored exponent always true exponent plus constant, never negative
// RULE6 - normalize: shift out leading zeros, decrement exponent per zero
// RULE7 - stored exponent 1..254 means normalized finite
// RULE8 - stored exponent zero is the denormal range
// RULE9 - exponent below -126: shift right, raise exponent until -126
// RULE10 - all bits shifted out gives a zero result
// RULE11 - plus and minus zero equal in value, sign kept
// RULE12 - zero result sign follows operation and rounding mode
// RULE13 - representable values always come out normalized
// RULE14 - creating a denormal result pulses underflow
// RULE15 - denormal source operand pulses denormal-operand
// RULE16 - six classes: zero, denormal, normal, infinity, NaN, indefinite
// RULE17 - infinity: exponent 255, fraction all zero
// RULE18 - exponent 255 nonzero fraction is NaN; top fraction bit quiet
// RULE19 - sign bit 31, exponent bits 30..23, fraction bits 22..0
// RULE20 - underflow and denormal-operand pulse with their result or operand
module fpsn_norm (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    input  wire logic                  i_enable,
    input  wire logic                  i_valid,
    input  wire fpsn_pkg::fpsn_op_t    i_op,
    input  wire fpsn_pkg::fpsn_round_t i_round,
    input  wire logic                  i_zero_neg_op,
    input  wire logic [31:0]           i_word,
    input  wire fpsn_pkg::fpsn_raw_t   i_raw,
    output logic                       o_valid,
    output logic [31:0]                o_word,
    output fpsn_pkg::fpsn_info_t       o_info,
    output logic                       o_operands_equal_zero,
    output logic                       o_underflow,
    output logic                       o_denormal_operand
);
    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // classify one packed word
    function automatic fpsn_pkg::fpsn_info_t classify(
        input logic [31:0] w
    );
        fpsn_pkg::fpsn_info_t r;
        logic [7:0]  e;
        logic [22:0] f;
        e = w[fpsn_pkg::EXP_HI:fpsn_pkg::EXP_LO]; // [RULE19]
        f = w[fpsn_pkg::FRAC_W-1:0];
        r.sign  = w[fpsn_pkg::SIGN_POS];           // [RULE1]
        r.quiet = f[fpsn_pkg::QUIET_POS];
        if (e == 8'h00 && f == 23'h000000) begin
            r.cls = fpsn_pkg::CLS_ZERO;            // [RULE16]
        end else if (e == 8'h00) begin
            r.cls = fpsn_pkg::CLS_DENORM;          // [RULE8]
        end else if (e >= fpsn_pkg::EXP_NORM_LO &&
                     e <= fpsn_pkg::EXP_NORM_HI) begin
            r.cls = fpsn_pkg::CLS_NORMAL;          // [RULE7]
        end else if (f == 23'h000000) begin
            r.cls = fpsn_pkg::CLS_INF;             // [RULE17]
        end else if (w[fpsn_pkg::SIGN_POS] &&
                     f == fpsn_pkg::INDEF_FRAC) begin
            r.cls = fpsn_pkg::CLS_INDEF;           // [RULE16]
        end else begin
            r.cls = fpsn_pkg::CLS_NAN;             // [RULE18]
        end
        return r;
    endfunction

    // sign of an exact zero result from operation and rounding mode
    function automatic logic zero_sign(
        input logic                  neg_op,
        input fpsn_pkg::fpsn_round_t rm
    );
        if (neg_op) begin
            return fpsn_pkg::SIGN_NEG_V;
        end else if (rm == fpsn_pkg::RM_DOWN) begin
            return fpsn_pkg::SIGN_NEG_V;
        end
        return fpsn_pkg::SIGN_POS_V;
    endfunction

    // ------------------------------------------------------------
    // stage 1: capture raw value, leading zeros from submodule
    // ------------------------------------------------------------
    fpsn_pkg::fpsn_raw_t raw_q;
    fpsn_pkg::fpsn_op_t  op_q;
    fpsn_pkg::fpsn_round_t rm_q;
    logic                neg_op_q;
    logic [31:0]         word_q;
    logic                valid_q;
    logic [4:0]          lz_count;

    fpsn_lzc #(
        .SIG_W (fpsn_pkg::SIG_W)
    ) u_lzc (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_enable(i_enable),
        .i_sig   (i_raw.sig),
        .o_count (lz_count)
    );

    // operand and request capture
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            raw_q    <= '0;
            op_q     <= fpsn_pkg::OP_CLASSIFY;
            rm_q     <= fpsn_pkg::RM_NEAREST;
            neg_op_q <= 1'b0;
            word_q   <= fpsn_pkg::RESET_WORD;
            valid_q  <= 1'b0;
        end else if (i_enable) begin
            raw_q    <= i_raw;
            op_q     <= i_op;
            rm_q     <= i_round;
            neg_op_q <= i_zero_neg_op;
            word_q   <= i_word;
            valid_q  <= i_valid;
        end
    end

    // ------------------------------------------------------------
    // stage 2: normalize and denormalize, combinational
    // ------------------------------------------------------------
    logic signed [10:0] exp_norm;
    logic signed [10:0] exp_min;
    logic signed [10:0] shift_r;
    logic [23:0]        sig_norm;
    logic [23:0]        sig_den;
    logic [31:0]        next_word;
    logic               next_uflow;
    logic               sig_zero;

    always_comb begin
        exp_min  = $signed({fpsn_pkg::TRUE_EXP_MIN[9],
                            fpsn_pkg::TRUE_EXP_MIN});
        sig_zero = (raw_q.sig == 24'h000000);
        // left shift removes leading zeros one exponent step each
        sig_norm = raw_q.sig << lz_count;                        // [RULE6]
        exp_norm = $signed({raw_q.true_exp[9], raw_q.true_exp})
                 - $signed({6'h00, lz_count});           // [RULE3] [RULE6]
        shift_r  = exp_min - exp_norm;
        sig_den  = sig_norm;
        next_uflow = 1'b0;
        if (sig_zero || raw_q.zero_by_sub) begin
            // exact zero: sign from operation and rounding
            next_word = {zero_sign(neg_op_q, rm_q), 31'h00000000}; // [RULE12]
        end else if (exp_norm >= exp_min) begin
            if (exp_norm > $signed(11'h07f)) begin
                next_word = {raw_q.sign, fpsn_pkg::EXP_MAX, 23'h000000};
            end else begin
                // biased exponent, implied integer bit dropped
                next_word = {raw_q.sign,                          // [RULE1]
                             8'(exp_norm + $signed({1'b0,
                                 fpsn_pkg::EXP_BIAS})),  // [RULE4] [RULE5]
                             sig_norm[fpsn_pkg::FRAC_W-1:0]};     // [RULE2]
            end
        end else begin
            // gradual underflow: right shift until minimum exponent
            if (shift_r >= $signed(11'd24)) begin
                sig_den = 24'h000000;                             // [RULE10]
            end else begin
                sig_den = sig_norm >> 5'(shift_r);                // [RULE9]
            end
            next_word  = {raw_q.sign, 8'h00, sig_den[22:0]};      // [RULE8]
            next_uflow = (sig_den != 24'h000000);                 // [RULE14]
            if (sig_den == 24'h000000) begin
                next_word = {raw_q.sign, 31'h00000000};           // [RULE10]
            end
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // result word and classification
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_word  <= fpsn_pkg::RESET_WORD;
            o_info  <= '0;
        end else if (i_enable) begin
            o_valid <= valid_q;
            if (op_q == fpsn_pkg::OP_PACK) begin
                o_word <= next_word;                              // [RULE13]
                o_info <= classify(next_word);
            end else begin
                o_word <= word_q;
                o_info <= classify(word_q);                       // [RULE16]
            end
        end
    end

    // zero compare ignores the sign bit
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_operands_equal_zero <= 1'b0;
        end else if (i_enable) begin
            o_operands_equal_zero <= (word_q[30:0] == 31'h00000000); // [RULE11]
        end
    end

    // single-cycle event pulses aligned with the output word
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_underflow        <= 1'b0;
            o_denormal_operand <= 1'b0;
        end else if (i_enable) begin
            o_underflow <= valid_q && op_q == fpsn_pkg::OP_PACK
                         && next_uflow;                            // [RULE20]
            o_denormal_operand <= valid_q && op_q == fpsn_pkg::OP_CLASSIFY
                && classify(word_q).cls == fpsn_pkg::CLS_DENORM;   // [RULE15]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_denorm_pulse;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && valid_q && op_q == fpsn_pkg::OP_CLASSIFY &&
         word_q[30:23] == 8'h00 && word_q[22:0] != 23'h000000)
        |=> o_denormal_operand;
    endproperty
    a_denorm_pulse: assert property (p_denorm_pulse) // [RULE15]
        else $error("denormal operand not flagged");

    property p_uflow_exp_zero;
        @(posedge i_clock) disable iff (i_reset)
        o_underflow |-> o_word[30:23] == 8'h00 && o_word[22:0] != 23'h0;
    endproperty
    a_uflow_exp_zero: assert property (p_uflow_exp_zero) // [RULE14]
        else $error("underflow without denormal result");

    property p_uflow_single;
        @(posedge i_clock) disable iff (i_reset)
        (o_underflow && i_enable && !(valid_q && next_uflow))
        |=> !o_underflow;
    endproperty
    a_uflow_single: assert property (p_uflow_single) // [RULE20]
        else $error("underflow pulse held too long");

    property p_bias_one;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && !sig_zero &&
         !raw_q.zero_by_sub && lz_count == 5'h00 &&
         raw_q.true_exp == 10'h000)
        |=> o_word[30:23] == 8'h7f;
    endproperty
    a_bias_one: assert property (p_bias_one) // [RULE4]
        else $error("exponent zero not biased to 127");

    property p_norm_class;
        @(posedge i_clock) disable iff (i_reset)
        (o_word[30:23] >= 8'h01 && o_word[30:23] <= 8'hfe)
        |-> o_info.cls == fpsn_pkg::CLS_NORMAL;
    endproperty
    a_norm_class: assert property (p_norm_class) // [RULE7]
        else $error("normal range misclassified");

    property p_inf_class;
        @(posedge i_clock) disable iff (i_reset)
        (o_word[30:23] == 8'hff && o_word[22:0] == 23'h0)
        |-> o_info.cls == fpsn_pkg::CLS_INF;
    endproperty
    a_inf_class: assert property (p_inf_class) // [RULE17]
        else $error("infinity misclassified");

    property p_nan_quiet;
        @(posedge i_clock) disable iff (i_reset)
        (o_info.cls == fpsn_pkg::CLS_NAN)
        |-> o_word[30:23] == 8'hff && o_info.quiet == o_word[22];
    endproperty
    a_nan_quiet: assert property (p_nan_quiet) // [RULE18]
        else $error("nan encoding or quiet bit wrong");

    property p_norm_msb;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && !sig_zero)
        |-> sig_norm[23];
    endproperty
    a_norm_msb: assert property (p_norm_msb) // [RULE6]
        else $error("normalized integer bit not one");

    property p_zero_sign;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && sig_zero &&
         !neg_op_q && rm_q == fpsn_pkg::RM_NEAREST)
        |=> o_word == 32'h00000000;
    endproperty
    a_zero_sign: assert property (p_zero_sign) // [RULE12]
        else $error("zero result sign wrong");

    property p_sign_kept;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && !sig_zero &&
         !raw_q.zero_by_sub)
        |=> o_word[31] == $past(raw_q.sign);
    endproperty
    a_sign_kept: assert property (p_sign_kept) // [RULE1]
        else $error("result sign not kept");

    property p_all_out_zero;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && !sig_zero &&
         shift_r >= $signed(11'd24))
        |=> o_word[30:0] == 31'h00000000 && !o_underflow;
    endproperty
    a_all_out_zero: assert property (p_all_out_zero) // [RULE10]
        else $error("fully shifted result not zero");

    property p_pack_normal;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_PACK && !sig_zero &&
         !raw_q.zero_by_sub && exp_norm >= exp_min)
        |=> o_word[30:23] != 8'h00 && !o_underflow;
    endproperty
    a_pack_normal: assert property (p_pack_normal) // [RULE13]
        else $error("representable result left denormal");

    property p_echo_word;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && op_q == fpsn_pkg::OP_CLASSIFY)
        |=> o_word == $past(word_q) && !o_underflow;
    endproperty
    a_echo_word: assert property (p_echo_word) // [RULE19]
        else $error("classified word not passed through");

    property p_pulse_needs_valid;
        @(posedge i_clock) disable iff (i_reset)
        (i_enable && !valid_q)
        |=> !o_underflow && !o_denormal_operand && !o_valid;
    endproperty
    a_pulse_needs_valid: assert property (p_pulse_needs_valid) // [RULE20]
        else $error("event pulse without a valid result");
endmodule

/* File: logic/fpsn_pkg.sv */
// package: single-format field layout, constants, classes and carriers
package fpsn_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int unsigned WORD_W    = 32;
    localparam int unsigned SIGN_POS  = 31;
    localparam int unsigned EXP_HI    = 30;
    localparam int unsigned EXP_LO    = 23;
    localparam int unsigned EXP_W     = 8;
    localparam int unsigned FRAC_W    = 23;
    localparam int unsigned SIG_W     = 24;
    localparam int unsigned QUIET_POS = 22;

    // ------------------------------------------------------------
    // exponent constants
    // ------------------------------------------------------------
    localparam logic [9:0] EXP_BIAS    = 10'h07f;
    localparam logic [7:0] EXP_MAX     = 8'hff;
    localparam logic [7:0] EXP_NORM_LO = 8'h01;
    localparam logic [7:0] EXP_NORM_HI = 8'hfe;
    localparam logic       SIGN_POS_V  = 1'h0;
    localparam logic       SIGN_NEG_V  = 1'h1;
    localparam logic [22:0] INDEF_FRAC = 23'h400000;
    localparam logic [9:0] TRUE_EXP_MIN = 10'h382;

    // ------------------------------------------------------------
    // reset values and pipeline latency
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam int unsigned LATENCY    = 1;

    // ------------------------------------------------------------
    // classes and operation kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_ZERO   = 3'b000,
        CLS_DENORM = 3'b001,
        CLS_NORMAL = 3'b010,
        CLS_INF    = 3'b011,
        CLS_NAN    = 3'b100,
        CLS_INDEF  = 3'b101
    } fpsn_class_t;

    typedef enum logic [1:0] {
        OP_CLASSIFY = 2'b00,
        OP_PACK     = 2'b01
    } fpsn_op_t;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'b00,
        RM_DOWN    = 2'b01,
        RM_UP      = 2'b10,
        RM_ZERO    = 2'b11
    } fpsn_round_t;

    // unpacked result from arithmetic: true exponent, 2's complement
    typedef struct packed {
        logic        sign;
        logic [9:0]  true_exp;
        logic [23:0] sig;
        logic        zero_by_sub;
    } fpsn_raw_t;

    // classification of one operand word
    typedef struct packed {
        fpsn_class_t cls;
        logic        sign;
        logic        quiet;
    } fpsn_info_t;

endpackage

/* File: logic/fpsn_lzc.sv */
// leading-zero counter for the 24-bit significand, registered output
`timescale 1ns/1ns
module fpsn_lzc #(
    parameter int unsigned SIG_W = 24
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic             i_enable,
    input  wire logic [SIG_W-1:0] i_sig,
    output logic      [4:0]       o_count
);
    // ------------------------------------------------------------
    // count from the top, registered
    // ------------------------------------------------------------
    function automatic logic [4:0] lz(input logic [SIG_W-1:0] v);
        logic [4:0] n;
        logic       hit;
        n   = 5'h00;
        hit = 1'b0;
        for (int i = SIG_W - 1; i >= 0; i--) begin
            if (!hit && !v[i]) begin
                n = n + 5'h01;
            end else begin
                hit = 1'b1;
            end
        end
        return n;
    endfunction

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_count <= 5'h00;
        end else if (i_enable) begin
            o_count <= lz(i_sig);
        end
    end
endmodule

/* File: testbench/fpsn_arith_model.sv */
// partner model: arithmetic pipeline feeding operands and raw results
`timescale 1ns/1ns
module fpsn_arith_model (
    input  wire logic             i_clock,
    output logic                  o_valid,
    output fpsn_pkg::fpsn_op_t    o_op,
    output fpsn_pkg::fpsn_round_t o_round,
    output logic                  o_zero_neg_op,
    output logic [31:0]           o_word,
    output fpsn_pkg::fpsn_raw_t   o_raw
);
    // idle values before the first request
    initial begin
        o_valid       = 1'h0;
        o_op          = fpsn_pkg::OP_CLASSIFY;
        o_round       = fpsn_pkg::RM_NEAREST;
        o_zero_neg_op = 1'h0;
        o_word        = 32'h0;
        o_raw         = '0;
    end

    // one request held across one rising edge, then data scrambled
    task automatic issue(input fpsn_pkg::fpsn_op_t op, input logic [31:0] w,
                         input fpsn_pkg::fpsn_raw_t r,
                         input fpsn_pkg::fpsn_round_t rm,
                         input logic neg, input logic v);
        @(negedge i_clock);
        o_op          = op;
        o_word        = w;
        o_raw         = r;
        o_round       = rm;
        o_zero_neg_op = neg;
        o_valid       = v;
        @(negedge i_clock);
        o_valid       = 1'h0;
        o_word        = ~w; // stale data must not be mistaken for live
        o_raw         = fpsn_pkg::fpsn_raw_t'(~r);
    endtask
endmodule

/* File: testbench/fp_single_format_normalizer_tb.sv */
// self-checking bench for the single-format normalizer
`timescale 1ns/1ns
module fp_single_format_normalizer_tb;
    logic                  i_clock;
    logic                  i_reset;
    logic                  i_enable;
    logic                  valid;
    fpsn_pkg::fpsn_op_t    op;
    fpsn_pkg::fpsn_round_t rm;
    logic                  neg;
    logic [31:0]           word;
    fpsn_pkg::fpsn_raw_t   raw;
    logic                  o_valid;
    logic [31:0]           o_word;
    fpsn_pkg::fpsn_info_t  o_info;
    logic                  o_eq_zero;
    logic                  o_underflow;
    logic                  o_denorm_op;
    int                    n_errors;
    int                    num_checks;

    // ------------------------------------------------------------
    // clock, model and design
    // ------------------------------------------------------------
    initial i_clock = 1'h0;
    always #4 i_clock = ~i_clock;

    fpsn_arith_model i_model (.i_clock(i_clock), .o_valid(valid), .o_op(op),
        .o_round(rm), .o_zero_neg_op(neg), .o_word(word), .o_raw(raw));

    fpsn_norm i_dut (.i_clock(i_clock), .i_reset(i_reset),
        .i_enable(i_enable), .i_valid(valid), .i_op(op), .i_round(rm),
        .i_zero_neg_op(neg), .i_word(word), .i_raw(raw), .o_valid(o_valid),
        .o_word(o_word), .o_info(o_info), .o_operands_equal_zero(o_eq_zero),
        .o_underflow(o_underflow), .o_denormal_operand(o_denorm_op));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what,
                     seen, exp);
        end
    endtask

    // bounded wait for a result
    task automatic wait_out;
        int k;
        k = 0;
        while (o_valid !== 1'h1 && k < 8) begin
            @(negedge i_clock);
            k++;
        end
        if (o_valid !== 1'h1) begin
            n_errors++;
            $display("unexpected at %0t: no result", $time);
            final_report();
        end
    endtask

    // valid and denormal pulse stay silent for n cycles
    task automatic silent(input int n);
        repeat (n) begin
            @(negedge i_clock);
            check({31'h0, o_valid}, 32'h0, "valid");
            check({31'h0, o_denorm_op}, 32'h0, "denorm pulse");
        end
    endtask

    function automatic logic [2:0] exp_cls(input logic [31:0] w);
        if (w[30:23] == 8'h0)
            return (w[22:0] == 23'h0) ? 3'h0 : 3'h1;
        if (w[30:23] != 8'hff) return 3'h2;
        if (w[22:0] == 23'h0) return 3'h3;
        return (w == 32'hffc00000) ? 3'h5 : 3'h4;
    endfunction

    // reference normalize and gradual underflow, truncating
    function automatic logic [31:0] exp_pack(input fpsn_pkg::fpsn_raw_t r);
        int          e;
        logic [23:0] s;
        e = int'($signed(r.true_exp));
        s = r.sig;
        while (s[23] == 1'h0 && s != 24'h0) begin
            s = s << 1;
            e--;
        end
        if (e > 127) return {r.sign, 8'hff, 23'h0};
        if (e >= -126) return {r.sign, 8'(e + 127), s[22:0]};
        s = s >> (-126 - e);
        return {r.sign, 8'h0, s[22:0]};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_classify;
        logic [31:0] w[11] = '{32'h0, 32'h80000000, 32'h1, 32'h807fffff,
            32'h800000, 32'h7f7fffff, 32'h7f800000, 32'hff800000,
            32'h7fc00000, 32'h7f800001, 32'hffc00000};
        foreach (w[i]) begin
            i_model.issue(fpsn_pkg::OP_CLASSIFY, w[i], '0,
                          fpsn_pkg::RM_NEAREST, 1'h0, 1'h1);
            wait_out();
            check(o_word, w[i], "word");
            check({29'h0, o_info.cls}, {29'h0, exp_cls(w[i])},
                  "cls");
            check({31'h0, o_info.sign}, {31'h0, w[i][31]}, "sign");
            if (exp_cls(w[i]) >= 3'h4)
                check({31'h0, o_info.quiet}, {31'h0, w[i][22]},
                      "quiet");
            check({31'h0, o_eq_zero}, {31'h0, w[i][30:0] == 31'h0},
                  "eqz");
            check({31'h0, o_denorm_op}, {31'h0, exp_cls(w[i]) == 3'h1},
                  "dop");
        end
    endtask

    task automatic t_pack;
        logic [31:0] e;
        fpsn_pkg::fpsn_raw_t r[12] = '{
        {1'h0, 10'h006, 24'hb22000, 1'h0}, {1'h0, 10'h000, 24'h000001, 1'h0},
        {1'h0, 10'h382, 24'h800000, 1'h0}, {1'h0, 10'h381, 24'h800000, 1'h0},
        {1'h0, 10'h37f, 24'haf0000, 1'h0}, {1'h0, 10'h36b, 24'h800000, 1'h0},
        {1'h0, 10'h36a, 24'h800000, 1'h0}, {1'h0, 10'h07f, 24'hffffff, 1'h0},
        {1'h0, 10'h080, 24'h800000, 1'h0}, {1'h1, 10'h000, 24'h800000, 1'h0},
        {1'h0, 10'h388, 24'h000010, 1'h0}, {1'h1, 10'h381, 24'hc00000, 1'h0}};
        foreach (r[i]) begin
            i_model.issue(fpsn_pkg::OP_PACK, 32'h0, r[i], fpsn_pkg::RM_NEAREST,
                          1'h0, 1'h1);
            wait_out();
            e = exp_pack(r[i]);
            check(o_word, e,
                  "pack");
            check({29'h0, o_info.cls}, {29'h0, exp_cls(e)},
                  "pcls");
            check({31'h0, o_underflow},
                  {31'h0, e[30:23] == 8'h0 && e[22:0] != 23'h0},
                  "uf");
            @(negedge i_clock);
            check({31'h0, o_underflow}, 32'h0, "uf pulse");
        end
    endtask

    // exact zero sign for every rounding mode
    task automatic t_zero_sign;
        fpsn_pkg::fpsn_round_t m;
        for (int k = 0; k < 8; k++) begin
            m = fpsn_pkg::fpsn_round_t'(k[1:0]);
            i_model.issue(fpsn_pkg::OP_PACK, 32'h0, {1'h0, 10'h0, 24'h0, 1'h1},
                          m, k[2], 1'h1);
            wait_out();
            check(o_word, {k[2] | (m == fpsn_pkg::RM_DOWN), 31'h0},
                  "zsign");
            check({31'h0, o_underflow}, 32'h0, "zuf");
        end
    endtask

    // no pulse without valid, no capture without enable, freeze holds data
    task automatic t_enable;
        i_model.issue(fpsn_pkg::OP_CLASSIFY, 32'h5, '0, fpsn_pkg::RM_NEAREST,
                      1'h0, 1'h0);
        silent(4);
        i_enable = 1'h0;
        i_model.issue(fpsn_pkg::OP_CLASSIFY, 32'h5, '0, fpsn_pkg::RM_NEAREST,
                      1'h0, 1'h1);
        i_enable = 1'h1;
        silent(4);
        i_model.issue(fpsn_pkg::OP_CLASSIFY, 32'h7, '0, fpsn_pkg::RM_NEAREST,
                      1'h0, 1'h1);
        i_enable = 1'h0;
        repeat (5) @(negedge i_clock);
        i_enable = 1'h1;
        wait_out();
        check(o_word, 32'h7, "frozen");
        check({31'h0, o_denorm_op}, 32'h1, "frozen dop");
    endtask

    // reset in mid flight clears outputs
    task automatic t_reset;
        i_model.issue(fpsn_pkg::OP_CLASSIFY, 32'h3, '0, fpsn_pkg::RM_NEAREST,
                      1'h0, 1'h1);
        i_reset = 1'h1;
        repeat (2) @(negedge i_clock);
        check({31'h0, o_valid}, 32'h0, "rst valid");
        check(o_word, 32'h0, "rst word");
        i_reset = 1'h0;
        silent(3);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors   = 0;
        num_checks = 0;
        i_reset    = 1'h1;
        i_enable   = 1'h1;
        repeat (8) @(negedge i_clock);
        i_reset = 1'h0;
        t_classify();
        t_pack();
        t_zero_sign();
        t_enable();
        t_reset();
        final_report();
    end
endmodule
